/* File: rtl/lact_regs.svh */
`ifndef LACT_REGS_SVH
`define LACT_REGS_SVH
// cross trigger timing, in analyzer clock cycles
`define LACT_TRIG_OUT_DLY 4'h9
`define LACT_TRIG_IN_ACK_DLY 1
// generation-time limits
`define LACT_NPROBE 4
`define LACT_PROBE_W 8
`define LACT_MU_MAX 5'h10
`define LACT_MU_MAX_CAP 5'h0F
`define LACT_MU_TOTAL_MAX 1024
`define LACT_HUB_CHAIN_DEF 4'h1
// peer register offsets, byte addresses
`define LACT_ADR_CTRL 4'h0
`define LACT_ADR_STAT 4'h4
`define LACT_ADR_ISTAT 4'h8
`define LACT_ADR_IMASK 4'hC
// ctrl bits
`define LACT_CTRL_FIRE 0
`define LACT_CTRL_AUTO_ACK 1
// status bits
`define LACT_STAT_DRIVING 0
`define LACT_STAT_TRIG_SEEN 1
`define LACT_STAT_ACKING 2
// interrupt bits
`define LACT_INT_TRIG_RX 0
`define LACT_INT_FIRE_DONE 1
`define LACT_INT_W 2
// reset values
`define LACT_CTRL_RST 2'h2
`define LACT_IMASK_RST 2'h0
`endif

/* File: rtl/lact_pkg.sv */
package lact_pkg;
    // trigger output sequence of the analyzer core
    typedef enum logic [1:0] {
        XO_ARMED,
        XO_DELAY,
        XO_HOLD,
        XO_DONE
    } lact_xo_e;
    // peer drive of the core trigger input
    typedef enum logic [1:0] {
        PD_IDLE,
        PD_DRIVE,
        PD_WAIT_LOW
    } lact_pd_e;
    typedef logic [4:0] lact_mu_t;
endpackage

/* File: rtl/lact_if.sv */
`timescale 1ns/1ps
// cross trigger link between analyzer core and its peer
interface lact_if;
    logic core_trig_out; // core trigger output
    logic core_trig_out_ack; // peer acknowledge of trigger output
    logic core_trig_in; // peer trigger into core
    logic core_trig_in_ack; // core acknowledge of trigger input
    modport core (
        output core_trig_out,
        input core_trig_out_ack,
        input core_trig_in,
        output core_trig_in_ack
    );
    modport peer (
        input core_trig_out,
        output core_trig_out_ack,
        output core_trig_in,
        input core_trig_in_ack
    );
endinterface

/* File: rtl/lact_core.sv */
// Contract
// R1: hold trigger out until acknowledge seen
// R2: ack tied low: hold until re-arm
// R3: input ack one cycle after input
// R4: trigger out nine cycles after event
// R5: acks fall only after trigger falls
// R6: trigger input driver is clock synchronous
// R7: chain: out to in, ack back
// R8: cross trigger ports exist only enabled; the code keeps disabled pairs and ties their outputs low
// R9: comparators per probe from 1 to 16
// R10: capture control reserves one comparator
// R11: common or per-probe counts, max 1024
// R12: probe roles trigger, data or both
// R13: hub user chain index, default 1
// R14: integrator picks a free chain index
// R15: acks sampled high on rising edge
`timescale 1ns/1ps
`include "lact_regs.svh"
module lact_core #(
    parameter bit TRIG_IN_EN = 1'b1, // trigger input pair present
    parameter bit TRIG_OUT_EN = 1'b1, // trigger output pair present
    parameter bit CAP_CTRL_EN = 1'b0, // capture filtering present
    parameter bit SAME_MU = 1'b1, // one count for every probe
    parameter lact_pkg::lact_mu_t ALL_MU = 5'h01, // common count
    parameter logic [19:0] MU_LIST = 20'h21111, // per-probe counts
    parameter logic [3:0] ROLE_TRIG = 4'hF, // probes feeding compare
    parameter logic [3:0] ROLE_DATA = 4'hF, // probes captured
    parameter logic [3:0] HUB_CHAIN = `LACT_HUB_CHAIN_DEF
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic [31:0] PROBE_I,
    input wire logic [511:0] CMP_VAL_I,
    input wire logic [63:0] CMP_EN_I,
    input wire logic ARM_I,
    lact_if.core XT,
    output logic TRIGGERED_O,
    output logic [31:0] CAP_DATA_O,
    output logic CAP_VALID_O,
    output logic [3:0] HUB_CHAIN_O
);
    localparam int NP = `LACT_NPROBE;
    localparam int PW = `LACT_PROBE_W;
    // four probes of sixteen slots keep the total at 64, far below
    // the per-core ceiling, so no probe count can exceed it
    localparam int TOTAL_MU = NP * 16; // see R11
    localparam bit TOTAL_OK = (TOTAL_MU <= `LACT_MU_TOTAL_MAX);

    // usable comparators for one probe after limits
    function automatic lact_pkg::lact_mu_t mu_of(input int p);
        lact_pkg::lact_mu_t m;
        lact_pkg::lact_mu_t lim;
        m = SAME_MU ? ALL_MU : MU_LIST[p*5 +: 5]; // see R11
        lim = CAP_CTRL_EN ? `LACT_MU_MAX_CAP : `LACT_MU_MAX; // see R10
        if (m > lim) begin
            m = lim; // see R9
        end
        if (m == 5'h00) begin
            m = 5'h01; // see R9
        end
        if (!TOTAL_OK) begin
            m = 5'h01;
        end
        return m;
    endfunction

    logic [NP-1:0] probe_hit; // any enabled comparator of a trigger-role probe matched
    logic [NP-1:0] probe_filt; // capture filter comparator matched
    logic trig_cond; // own trigger condition this cycle
    logic cap_ok; // capture filter verdict this cycle
    logic trig_in_used; // trigger input taken this cycle
    logic fire; // event starting the trigger out delay
    lact_pkg::lact_xo_e xo_q; // trigger output sequence state
    logic [3:0] dly_q; // cycles since event
    logic trig_out_q; // trigger output flop
    logic trig_in_ack_q; // trigger input acknowledge flop
    logic triggered_q; // core has fired since last arm
    logic [31:0] cap_data_q; // captured data-role probes
    logic cap_valid_q; // capture sample qualifier
    logic [3:0] hub_chain_q; // chain index presented to the hub

    // comparator bank, one slot per comparator up to the probe count
    for (genvar p = 0; p < NP; p++) begin : g_probe
        localparam lact_pkg::lact_mu_t MU = mu_of(p);
        logic [15:0] slot_hit;
        for (genvar c = 0; c < 16; c++) begin : g_cmp
            // slots beyond the probe's count are not built
            if (c < int'(MU)) begin : g_on
                assign slot_hit[c] = CMP_EN_I[p*16+c]
                    && (PROBE_I[p*PW +: PW] == CMP_VAL_I[(p*16+c)*PW +: PW]);
            end else begin : g_off
                assign slot_hit[c] = 1'b0;
            end
        end
        // only trigger-role probes reach the trigger decision
        assign probe_hit[p] = ROLE_TRIG[p] && (|slot_hit); // see R12
        // the top slot is kept for capture filtering
        if (CAP_CTRL_EN) begin : g_filt
            assign probe_filt[p] = CMP_EN_I[p*16+15]
                && (PROBE_I[p*PW +: PW] == CMP_VAL_I[(p*16+15)*PW +: PW]);
        end else begin : g_nofilt
            assign probe_filt[p] = 1'b0;
        end
    end

    // trigger decision and its event sources
    always_comb begin
        trig_cond = |probe_hit;
        cap_ok = CAP_CTRL_EN ? |(probe_filt & ROLE_DATA) : 1'b1;
        // the input is synchronous to this clock and read unsynchronised
        trig_in_used = TRIG_IN_EN && XT.core_trig_in; // see R6
        fire = trig_in_used || trig_cond; // see R4
    end

    // trigger output sequence: arm, delay, hold, done
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            xo_q <= lact_pkg::XO_ARMED;
            dly_q <= 4'h0;
            trig_out_q <= 1'b0;
        end else if (ARM_I) begin
            // re-arm always works, even with the ack tied low
            xo_q <= lact_pkg::XO_ARMED; // see R2
            dly_q <= 4'h0;
            trig_out_q <= 1'b0; // see R2
        end else begin
            case (xo_q)
                lact_pkg::XO_ARMED: begin
                    if (fire) begin
                        xo_q <= lact_pkg::XO_DELAY;
                        dly_q <= 4'h1;
                    end
                end
                lact_pkg::XO_DELAY: begin
                    // output rises in the ninth cycle after the event
                    if (dly_q == `LACT_TRIG_OUT_DLY - 4'h1) begin
                        trig_out_q <= TRIG_OUT_EN; // see R4
                        xo_q <= lact_pkg::XO_HOLD;
                    end else begin
                        dly_q <= dly_q + 4'h1;
                    end
                end
                lact_pkg::XO_HOLD: begin
                    // ack sampled high at a rising edge drops the output
                    if (XT.core_trig_out_ack || !TRIG_OUT_EN) begin // see R15
                        trig_out_q <= 1'b0; // see R1
                        xo_q <= lact_pkg::XO_DONE;
                    end
                end
                lact_pkg::XO_DONE: begin
                    // one shot per arm; wait for the next arm
                    trig_out_q <= 1'b0;
                end
                default: begin
                    xo_q <= lact_pkg::XO_ARMED;
                    trig_out_q <= 1'b0;
                end
            endcase
        end
    end

    // input acknowledge: one cycle behind the input, falls after it
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            trig_in_ack_q <= 1'b0;
        end else begin
            // a plain register gives exactly one cycle of lag both ways
            trig_in_ack_q <= trig_in_used; // see R3, R5
        end
    end

    // triggered flag for the user
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            triggered_q <= 1'b0;
        end else if (ARM_I) begin
            triggered_q <= 1'b0;
        end else if (xo_q == lact_pkg::XO_ARMED && fire) begin
            triggered_q <= 1'b1;
        end
    end

    // capture path: data-role probes only, qualified by the filter
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cap_data_q <= 32'h00000000;
            cap_valid_q <= 1'b0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                // trigger-only probes never reach capture
                cap_data_q[p*PW +: PW] <= ROLE_DATA[p] ?
                    PROBE_I[p*PW +: PW] : 8'h00; // see R12
            end
            cap_valid_q <= cap_ok; // see R10
        end
    end

    // hub chain index, fixed at generation time
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            hub_chain_q <= `LACT_HUB_CHAIN_DEF;
        end else begin
            // the integrator keeps this clear of other scan users
            hub_chain_q <= HUB_CHAIN; // see R13
        end
    end

    // disabled pairs are held low so they act as absent
    assign XT.core_trig_out = TRIG_OUT_EN ? trig_out_q : 1'b0; // see R8
    assign XT.core_trig_in_ack = TRIG_IN_EN ? trig_in_ack_q : 1'b0; // see R8
    assign TRIGGERED_O = triggered_q;
    assign CAP_DATA_O = cap_data_q;
    assign CAP_VALID_O = cap_valid_q;
    assign HUB_CHAIN_O = hub_chain_q;
endmodule

/* File: rtl/lact_peer.sv */
`timescale 1ns/1ps
`include "lact_regs.svh"
// peer end: software drives and acknowledges cross triggers
module lact_peer (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    lact_if.peer XT,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic IRQ_O
);
    logic req; // new bus access this cycle
    logic wr; // write strobe, low byte lane
    logic [1:0] ctrl_q; // control register
    logic [1:0] istat_q; // sticky interrupt status
    logic [1:0] imask_q; // interrupt mask
    logic [1:0] ev; // events this cycle
    logic [31:0] dat_q; // read data
    logic ack_q; // bus acknowledge
    logic irq_q; // interrupt output flop
    lact_pkg::lact_pd_e pd_q; // drive state of the core trigger input
    logic trig_in_q; // core trigger input flop
    logic out_ack_q; // acknowledge of core trigger output
    logic seen_q; // core trigger output seen high last cycle

    assign req = WB_CYC_I && WB_STB_I && !ack_q;
    assign wr = req && WB_WE_I && WB_SEL_I[0];

    // bus answer one cycle after the request, dropped the next cycle
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= req;
            dat_q <= 32'h00000000;
            if (req && !WB_WE_I) begin
                case (WB_ADR_I)
                    `LACT_ADR_CTRL: dat_q[1:0] <= ctrl_q;
                    `LACT_ADR_STAT: begin
                        dat_q[`LACT_STAT_DRIVING] <= trig_in_q;
                        dat_q[`LACT_STAT_TRIG_SEEN] <= seen_q;
                        dat_q[`LACT_STAT_ACKING] <= out_ack_q;
                    end
                    `LACT_ADR_ISTAT: dat_q[1:0] <= istat_q;
                    `LACT_ADR_IMASK: dat_q[1:0] <= imask_q;
                    // unmapped offsets read zero
                    default: dat_q <= 32'h00000000;
                endcase
            end
        end
    end

    // control and mask registers; fire bit self-clears
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_q <= `LACT_CTRL_RST;
            imask_q <= `LACT_IMASK_RST;
        end else begin
            ctrl_q[`LACT_CTRL_FIRE] <= 1'b0;
            if (wr && WB_ADR_I == `LACT_ADR_CTRL) begin
                ctrl_q <= WB_DAT_I[1:0];
            end
            if (wr && WB_ADR_I == `LACT_ADR_IMASK) begin
                imask_q <= WB_DAT_I[1:0];
            end
        end
    end

    // drive the core trigger input until the core acknowledges
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pd_q <= lact_pkg::PD_IDLE;
            trig_in_q <= 1'b0;
        end else begin
            case (pd_q)
                lact_pkg::PD_IDLE: begin
                    // a fire request while busy is dropped
                    if (ctrl_q[`LACT_CTRL_FIRE]) begin
                        trig_in_q <= 1'b1; // see R6
                        pd_q <= lact_pkg::PD_DRIVE;
                    end
                end
                lact_pkg::PD_DRIVE: begin
                    if (XT.core_trig_in_ack) begin
                        trig_in_q <= 1'b0;
                        pd_q <= lact_pkg::PD_WAIT_LOW;
                    end
                end
                lact_pkg::PD_WAIT_LOW: begin
                    // no new drive until the core ack has fallen
                    if (!XT.core_trig_in_ack) begin // see R5
                        pd_q <= lact_pkg::PD_IDLE;
                    end
                end
                default: begin
                    pd_q <= lact_pkg::PD_IDLE;
                    trig_in_q <= 1'b0;
                end
            endcase
        end
    end

    // acknowledge the core trigger output; fall only after it falls
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            out_ack_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            seen_q <= XT.core_trig_out;
            // ack rises one cycle after the output while auto-ack is on; once given
            // it stands until the output falls, so clearing auto-ack
            // late never drops it while the trigger is still high
            out_ack_q <= XT.core_trig_out
                && (ctrl_q[`LACT_CTRL_AUTO_ACK] || out_ack_q); // see R5
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_comb begin
        ev[`LACT_INT_TRIG_RX] = XT.core_trig_out && !seen_q;
        ev[`LACT_INT_FIRE_DONE] = (pd_q == lact_pkg::PD_DRIVE)
            && XT.core_trig_in_ack;
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            istat_q <= 2'h0;
            irq_q <= 1'b0;
        end else begin
            if (wr && WB_ADR_I == `LACT_ADR_ISTAT) begin
                istat_q <= (istat_q & ~WB_DAT_I[1:0]) | ev;
            end else begin
                istat_q <= istat_q | ev;
            end
            irq_q <= |(istat_q & imask_q);
        end
    end

    assign XT.core_trig_in = trig_in_q; // see R7
    assign XT.core_trig_out_ack = out_ack_q; // see R7
    assign WB_DAT_O = dat_q;
    assign WB_ACK_O = ack_q;
    assign IRQ_O = irq_q;
endmodule

/* File: verif/lact_xt_properties.sv */
`timescale 1ns/1ps
// watches the cross trigger wires between the core and its peer
module lact_xt_checker (
    input wire logic CLK_SYS_I, // analyzer clock
    input wire logic RST_N_I, // async reset, active low
    input wire logic core_trig_out, // core trigger output
    input wire logic core_trig_out_ack, // peer acknowledge of it
    input wire logic core_trig_in, // peer trigger into core
    input wire logic core_trig_in_ack, // core acknowledge of it
    input wire logic ARM_I, // re-arm pulse into the core
    input wire logic TRIGGERED_O // core has taken its event
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);
    // event taken, and no re-arm cuts the delay short
    sequence s_fired;
        $rose(TRIGGERED_O) && !ARM_I ##1 !ARM_I [*7];
    endsequence
    // input acknowledge answers in the very next cycle
    sequence s_in_answer;
        !core_trig_in_ack ##1 core_trig_in_ack;
    endsequence
    AST_IN_ACK_RISE: assert property (
        $rose(core_trig_in) |-> s_in_answer)
        else $error("input ack not one cycle after input");
    AST_IN_ACK_CAUSE: assert property (
        $rose(core_trig_in_ack) |-> $past(core_trig_in))
        else $error("input ack rose without input");
    AST_IN_ACK_HOLD: assert property (
        core_trig_in && core_trig_in_ack |=> core_trig_in_ack)
        else $error("input ack fell while input high");
    AST_IN_ACK_FALL: assert property (
        $fell(core_trig_in_ack) |-> !$past(core_trig_in))
        else $error("input ack fell too early");
    AST_OUT_ACK_HOLD: assert property (
        core_trig_out && core_trig_out_ack |=> core_trig_out_ack)
        else $error("output ack fell while output high");
    AST_OUT_ACK_FALL: assert property (
        $fell(core_trig_out_ack) |-> !$past(core_trig_out))
        else $error("output ack fell too early");
    AST_OUT_HOLD: assert property (
        core_trig_out && !core_trig_out_ack && !ARM_I |=> core_trig_out)
        else $error("trigger output dropped unacknowledged");
    AST_OUT_DROP: assert property (
        core_trig_out && (core_trig_out_ack || ARM_I) |=> !core_trig_out)
        else $error("trigger output kept after ack or arm");
    AST_OUT_DLY: assert property (
        s_fired |=> core_trig_out)
        else $error("trigger output late");
    AST_OUT_EARLY: assert property (
        $rose(TRIGGERED_O) |-> !core_trig_out [*8])
        else $error("trigger output early");
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
`include "lact_regs.svh"
// core and peer joined by the link; software side drives the peer
module tb;
    logic CLK_SYS_I = 1'b0; // 40 MHz analyzer clock
    logic RST_N_I = 1'b0; // held low at start
    logic [31:0] PROBE_I = 32'h00000000; // probe lanes
    logic [511:0] CMP_VAL_I = 512'h5A; // slot 0 of probe 0 only
    logic [63:0] CMP_EN_I = 64'h0000000000000001; // one live slot
    logic ARM_I = 1'b0; // re-arm pulse
    logic TRIGGERED_O, CAP_VALID_O, WB_ACK_O, IRQ_O;
    logic [31:0] CAP_DATA_O, WB_DAT_O;
    logic [3:0] HUB_CHAIN_O;
    logic WB_CYC_I = 1'b0; // bus request, cyc and stb move together
    logic WB_STB_I = 1'b0;
    logic WB_WE_I = 1'b0;
    logic [3:0] WB_ADR_I = 4'h0;
    logic [31:0] WB_DAT_I = 32'h00000000;
    logic [3:0] WB_SEL_I = 4'h0; // byte lanes, driven with the request
    // second core: no link pairs, capture control, split probe roles
    lact_if xt_b_if ();
    logic [511:0] cmp_val_b = {256'h0, 8'h3C, 112'h0, 8'h3C, 8'h66,
        8'h99, 112'h0}; // probe 0 slots 14 and 15, probe 1 slots 0, 15
    logic [63:0] cmp_en_b = 64'h000000008001C000; // those four slots
    logic trig_b, cap_valid_b; // second core outputs
    logic [31:0] cap_data_b;
    logic [3:0] hub_b;
    int failures = 0; // mismatches
    int n_compared = 0; // comparisons
    int cyc_n = 0; // edge stamp
    int t_in, t_ack, t_out; // stamps of the link rises
    logic in_q = 1'b0, ack_q = 1'b0, out_q = 1'b0; // last sampled levels
    lact_if xt_if ();
    lact_core lact_core_i (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
        .PROBE_I(PROBE_I), .CMP_VAL_I(CMP_VAL_I), .CMP_EN_I(CMP_EN_I),
        .ARM_I(ARM_I), .XT(xt_if), .TRIGGERED_O(TRIGGERED_O),
        .CAP_DATA_O(CAP_DATA_O), .CAP_VALID_O(CAP_VALID_O),
        .HUB_CHAIN_O(HUB_CHAIN_O));
    lact_core #(.TRIG_IN_EN(1'b0), .TRIG_OUT_EN(1'b0), .CAP_CTRL_EN(1'b1),
        .ALL_MU(5'h10), .ROLE_TRIG(4'h1), .ROLE_DATA(4'h2),
        .HUB_CHAIN(4'h3)) // chain kept clear of core one
    lact_core_i2 (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
        .PROBE_I(PROBE_I), .CMP_VAL_I(cmp_val_b), .CMP_EN_I(cmp_en_b),
        .ARM_I(ARM_I), .XT(xt_b_if), .TRIGGERED_O(trig_b),
        .CAP_DATA_O(cap_data_b), .CAP_VALID_O(cap_valid_b),
        .HUB_CHAIN_O(hub_b));
    // sel is driven with every request; the bench writes whole words
    lact_peer lact_peer_i (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
        .XT(xt_if), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
        .IRQ_O(IRQ_O));
    lact_xt_checker lact_xt_checker_i (.CLK_SYS_I(CLK_SYS_I),
        .RST_N_I(RST_N_I), .ARM_I(ARM_I), .TRIGGERED_O(TRIGGERED_O),
        .core_trig_out(xt_if.core_trig_out),
        .core_trig_out_ack(xt_if.core_trig_out_ack),
        .core_trig_in(xt_if.core_trig_in),
        .core_trig_in_ack(xt_if.core_trig_in_ack));
    // clock: invert every half period
    always #12.5 CLK_SYS_I = ~CLK_SYS_I;
    // stamp the first edge at which each link signal is sampled high
    always @(posedge CLK_SYS_I) begin
        cyc_n <= cyc_n + 1;
        in_q <= xt_if.core_trig_in;
        ack_q <= xt_if.core_trig_in_ack;
        out_q <= xt_if.core_trig_out;
        if (xt_if.core_trig_in === 1'b1 && in_q !== 1'b1) t_in <= cyc_n;
        if (xt_if.core_trig_in_ack === 1'b1 && ack_q !== 1'b1) t_ack <= cyc_n;
        if (xt_if.core_trig_out === 1'b1 && out_q !== 1'b1) t_out <= cyc_n;
    end
    task automatic conclude;
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // a bound ran out: count it and stop the run
    task automatic timeout(input string what);
        failures++;
        $display("MISMATCH %s expected done seen timeout", what);
        conclude();
    endtask
    // let the edge's updates land before looking
    task automatic tick;
        @(posedge CLK_SYS_I);
        #1;
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [3:0] adr,
                      input logic [31:0] dat, output logic [31:0] rd);
        int i;
        @(posedge CLK_SYS_I);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_SEL_I <= 4'hF;
        WB_ADR_I <= adr;
        WB_DAT_I <= dat;
        for (i = 0; i < 16; i++) begin
            @(posedge CLK_SYS_I);
            if (WB_ACK_O === 1'b1) break;
        end
        if (i == 16) timeout("wb_ack");
        rd = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        tick();
    endtask
    task automatic wait_out;
        int i;
        for (i = 0; i < 40 && xt_if.core_trig_out !== 1'b1; i++) tick();
        if (i == 40) timeout("trig_out");
        // the rise is stamped at the edge that samples it, one later
        tick();
    endtask
    task automatic arm_pulse;
        @(posedge CLK_SYS_I);
        ARM_I <= 1'b1;
        @(posedge CLK_SYS_I);
        ARM_I <= 1'b0;
        #1;
    endtask
    // peer fires into the core, core answers and fires back, auto ack
    task automatic scen_link;
        logic [31:0] rd;
        int i;
        wb(1'b1, `LACT_ADR_CTRL, 32'h3, rd);
        wait_out();
        chk("in_ack_delay", t_ack - t_in, 32'h1);
        chk("out_delay", t_out - t_in, 32'h9);
        chk("triggered", TRIGGERED_O, 32'h1);
        for (i = 0; i < 8; i++) tick();
        chk("link_idle", {xt_if.core_trig_out, xt_if.core_trig_out_ack,
            xt_if.core_trig_in, xt_if.core_trig_in_ack}, 32'h0);
        // both events latched, interrupt masked until enabled
        wb(1'b0, `LACT_ADR_ISTAT, 32'h0, rd);
        chk("istat", rd, 32'h3);
        chk("irq_masked", IRQ_O, 32'h0);
        wb(1'b1, `LACT_ADR_IMASK, 32'h2, rd);
        chk("irq_on", IRQ_O, 32'h1);
        wb(1'b1, `LACT_ADR_ISTAT, 32'h2, rd);
        chk("irq_cleared", IRQ_O, 32'h0);
        wb(1'b0, `LACT_ADR_ISTAT, 32'h0, rd);
        chk("istat_left", rd, 32'h1);
        arm_pulse();
        chk("rearmed", TRIGGERED_O, 32'h0);
    endtask
    // comparator fires, nobody acks: output stands until re-arm
    task automatic scen_no_ack;
        logic [31:0] rd;
        int t_pr;
        wb(1'b1, `LACT_ADR_CTRL, 32'h0, rd);
        @(posedge CLK_SYS_I);
        PROBE_I <= 32'h0000005A;
        #1;
        t_pr = cyc_n;
        wait_out();
        chk("cmp_delay", t_out - t_pr, 32'h9);
        chk("cap_data", CAP_DATA_O, 32'h0000005A);
        chk("cap_valid", CAP_VALID_O, 32'h1);
        repeat (20) tick();
        chk("out_held", xt_if.core_trig_out, 32'h1);
        wb(1'b0, `LACT_ADR_STAT, 32'h0, rd);
        chk("stat", rd, 32'h2);
        @(posedge CLK_SYS_I);
        PROBE_I <= 32'h00000000;
        arm_pulse();
        chk("out_dropped", xt_if.core_trig_out, 32'h0);
        repeat (12) tick();
        chk("out_quiet", xt_if.core_trig_out, 32'h0);
    endtask
    // second core: split roles, reserved filter slot, pairs disabled
    task automatic scen_cfg;
        @(posedge CLK_SYS_I);
        PROBE_I <= 32'h00003C00;
        xt_b_if.core_trig_in <= 1'b1;
        repeat (3) tick();
        chk("cfg_untriggered", trig_b, 32'h0);
        chk("cfg_in_ack", xt_b_if.core_trig_in_ack, 32'h0);
        chk("cfg_cap_data", cap_data_b, 32'h00003C00);
        chk("cfg_cap_valid", cap_valid_b, 32'h1);
        @(posedge CLK_SYS_I);
        PROBE_I <= 32'h00000066;
        repeat (3) tick();
        chk("cfg_filter_slot", trig_b, 32'h0);
        chk("cfg_filter_off", cap_valid_b, 32'h0);
        chk("cfg_trig_only", cap_data_b, 32'h0);
        @(posedge CLK_SYS_I);
        PROBE_I <= 32'h00000099;
        repeat (12) tick();
        chk("cfg_slot_14", trig_b, 32'h1);
        chk("cfg_out_off", xt_b_if.core_trig_out, 32'h0);
        @(posedge CLK_SYS_I);
        PROBE_I <= 32'h00000000;
        xt_b_if.core_trig_in <= 1'b0;
    endtask
    // reset, plain register checks, then the scenarios
    initial begin
        logic [31:0] rd;
        xt_b_if.core_trig_in <= 1'b0;
        xt_b_if.core_trig_out_ack <= 1'b0;
        repeat (3) @(posedge CLK_SYS_I);
        RST_N_I <= 1'b1;
        tick();
        chk("hub_chain", HUB_CHAIN_O, 32'h1);
        chk("hub_chain_b", hub_b, 32'h3);
        wb(1'b0, `LACT_ADR_CTRL, 32'h0, rd);
        chk("ctrl_rst", rd, 32'h2);
        wb(1'b0, 4'h6, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        scen_link();
        scen_no_ack();
        scen_cfg();
        conclude();
    end
endmodule
